// ==== ces_pkg.sv ====
// package: engine status and control constants, types and helpers
package ces_pkg;
   // data memory word addresses
   localparam logic [7:0] ADDR_CONFIG = 8'h20;
   localparam logic [7:0] ADDR_STATUS = 8'h80;
   // configuration reset value and writable bits (bit 4, 31:20 unused)
   localparam logic [31:0] CONFIG_RESET = 32'h00005020;
   localparam logic [31:0] CONFIG_WMASK = 32'h000fffef;
   // status reset value
   localparam logic [31:0] STATUS_RESET = 32'h00000000;
   // phase select codes
   localparam logic [1:0] PHASE_A = 2'h0;
   localparam logic [1:0] PHASE_B = 2'h1;
   // meter equation codes
   localparam logic [2:0] EQU_SINGLE = 3'h0;
   localparam logic [2:0] EQU_DUAL = 3'h2;
   // shift amounts: gain 8, boost 16, reduce 64
   localparam int GAIN8_SHIFT = 3;
   localparam int BOOST_SHIFT = 4;
   localparam int REDUCE_SHIFT = 6;
   // unity channel gain scale and temperature term scaling
   localparam logic [15:0] GAIN_UNITY = 16'h4000;
   localparam logic [15:0] GAIN_MAX = 16'hffff;
   localparam int LIN_SHIFT = 14;
   localparam int QUAD_SHIFT = 22;

   // configuration word layout, msb first
   typedef struct packed {
      logic [11:0] unused_hi;
      logic sag_mask_hi;            // phase b joins sag interrupt
      logic sag_mask_lo;            // phase a joins sag interrupt
      logic sag_int_en;             // sag interrupt onto aux pin
      logic temp_comp_external;     // processor owns gain scale
      logic [7:0] sag_sample_count; // samples below threshold
      logic phase_select_hi;
      logic phase_select_lo;
      logic pulse_source_external;  // rates from processor words
      logic unused4;
      logic current_b_gain8;
      logic current_a_gain8;
      logic pulse_boost;            // pulse input times 16
      logic pulse_reduce;           // pulse input divided by 64
   } ces_cfg_s;

   // status word layout, msb first
   typedef struct packed {
      logic [2:0] zero_hi;
      logic fundamental_square_wave;
      logic reserved27;
      logic sag_b;
      logic sag_a;
      logic [24:0] zero_lo;
   } ces_status_s;

   // per-element accumulated sums
   typedef struct packed {
      logic signed [31:0] element0_watt_sum;
      logic signed [31:0] element1_watt_sum;
      logic signed [31:0] element0_var_sum;
      logic signed [31:0] element1_var_sum;
      logic [31:0] element0_current_sq_sum;
      logic [31:0] element1_current_sq_sum;
   } ces_sums_s;

   // four pulse rate words
   typedef struct packed {
      logic signed [31:0] watt;
      logic signed [31:0] var_rate;
      logic signed [31:0] third;
      logic signed [31:0] fourth;
   } ces_rates_s;

   // temperature compensation inputs
   typedef struct packed {
      logic signed [15:0] temp_coef_linear;
      logic signed [15:0] temp_coef_quadratic;
      logic signed [15:0] temp_diff;
   } ces_temp_s;

   // clamp a wide signed value into 32 bits
   function automatic logic [31:0] ces_sat32(input logic signed [47:0] v);
      if (v > 48'sh00007fffffff) begin
         return 32'h7fffffff;
      end else if (v < -48'sh000080000000) begin
         return 32'h80000000;
      end else begin
         return v[31:0];
      end
   endfunction : ces_sat32
endpackage : ces_pkg

// ==== ces_sag_detect.sv ====
// module: per-phase sag detector counting low samples
module ces_sag_detect (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic sample_en,
   input wire logic signed [31:0] sample,
   input wire logic [31:0] sag_threshold,
   input wire logic [7:0] sag_sample_count,
   output logic sag
);
   import ces_pkg::*;

   logic [7:0] count_reg;   // consecutive low samples, saturating
   logic [7:0] count_next;
   logic [31:0] mag;        // sample magnitude
   logic above;             // sample above threshold

   // magnitude with the most negative value clamped
   assign mag = (sample == 32'sh80000000) ? 32'h7fffffff :
                (sample < 0) ? 32'(-sample) : 32'(sample);
   assign above = mag > sag_threshold;
   assign count_next = (count_reg == 8'hff) ? count_reg : count_reg + 8'h01;

   // count low samples, clear on any sample above threshold
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         count_reg <= 8'h00;
         sag <= 1'b0;
      end else if (sample_en) begin
         if (above) begin
            count_reg <= 8'h00;
            sag <= 1'b0;
         end else begin
            count_reg <= count_next;
            if (count_next >= sag_sample_count) begin
               sag <= 1'b1;
            end
         end
      end
   end
endmodule : ces_sag_detect

// ==== ces_pulse_scale.sv ====
// module: pulse generator input gain stage
module ces_pulse_scale (
   input wire logic pulse_boost,
   input wire logic pulse_reduce,
   input wire logic signed [31:0] value_in,
   output logic signed [31:0] value_out
);
   import ces_pkg::*;

   // boost by 16, reduce by 64, forbidden pair passes unchanged
   always_comb begin
      value_out = value_in;
      if (pulse_boost && !pulse_reduce) begin
         value_out = ces_sat32(48'(value_in) <<< BOOST_SHIFT);
      end else if (pulse_reduce && !pulse_boost) begin
         value_out = value_in >>> REDUCE_SHIFT;
      end
   end
endmodule : ces_pulse_scale

// ==== ces_engine.sv ====
// module: compute engine status and configuration words
// Behaviour
// - status rewritten once per pass with done pulse
// - sag flags fresh each pass, never latched
// - status bits 31:29 and 24:0 read zero
// - bit 28 square wave at selected fundamental
// - bit 26 sag on input b
// - bit 25 sag on input a
// - shunt bits add gain eight to current
// - external source uses four processor rate words
// - equation 0 picks larger-current element watt sum
// - equation 2 adds both elements' watt, var
// - internal temperature compensation adjusts gain scale
// - external compensation leaves gain to processor
// - phase select drives frequency tracking loop
// - bit 17 routes sag interrupt to aux pin
// - sag masks; all selected phases must sag
// - bits 15:8 sag sample count, default 80
// - phase codes: 0/0 a, 0/1 b
// - bit 5 pulse source select, default external
// - boost 16, reduce 64, both forbidden
module ces_engine (
   input wire logic sys_clk,
   input wire logic rst_n,
   // data memory word port
   input wire logic [7:0] ce_addr,
   input wire logic ce_wr_en,
   input wire logic [31:0] ce_wdata,
   input wire logic ce_rd_en,
   output logic [31:0] ce_rdata,
   // one sample frame per pass
   input wire logic sample_valid,
   input wire logic signed [31:0] voltage_in_a,
   input wire logic signed [31:0] voltage_in_b,
   input wire logic signed [31:0] current_in_a,
   input wire logic signed [31:0] current_in_b,
   // words held elsewhere in data memory
   input wire logic [31:0] sag_threshold,
   input wire logic [2:0] meter_equation,
   input wire ces_pkg::ces_sums_s sums,
   input wire ces_pkg::ces_rates_s ext_rates,
   input wire ces_pkg::ces_temp_s temp_in,
   input wire logic [15:0] mpu_gain_scale,
   // normal pulse function of the shared aux pin
   input wire logic aux_pulse_src,
   // results
   output logic pass_done,
   output logic signed [31:0] current_a_scaled,
   output logic signed [31:0] current_b_scaled,
   output ces_pkg::ces_rates_s pulse_rates,
   output logic [15:0] channel_gain_scale,
   output logic pll_phase_b,
   output logic sag_irq,
   output logic aux_pulse_out
);
   import ces_pkg::*;

   // pass sequencer states
   typedef enum logic [1:0] {
      PASS_IDLE,
      PASS_EVAL,
      PASS_DONE
   } ces_pass_e;

   ces_pass_e state_reg;        // current pass step
   ces_pass_e state_next;
   ces_cfg_s cfg_reg;           // configuration word
   ces_status_s status_reg;     // status word as software sees it
   ces_status_s status_next;
   logic [1:0] phase_sel;       // phase select pair
   logic sel_b;                 // tracking follows phase b
   logic f0_reg;                // live fundamental square wave
   logic sag_a;                 // live sag flag, phase a
   logic sag_b;                 // live sag flag, phase b
   logic sag_irq_next;          // combined masked sag condition
   logic [15:0] gain_calc_reg;  // gain computed in eval step
   ces_rates_s int_rates;       // internally chosen pulse inputs
   ces_rates_s raw_rates;       // source-selected pulse inputs
   ces_rates_s scaled_rates;    // after boost or reduce
   logic signed [31:0] sel_voltage; // voltage of tracked phase

   // temperature adjusted gain scale, clamped to 16 bits
   function automatic logic [15:0] temp_gain(input ces_temp_s t);
      logic signed [47:0] lin_term;
      logic signed [47:0] quad_term;
      logic signed [47:0] total;
      lin_term = (48'(t.temp_coef_linear) * 48'(t.temp_diff))
                 >>> LIN_SHIFT;
      quad_term = (48'(t.temp_coef_quadratic) * 48'(t.temp_diff)
                  * 48'(t.temp_diff)) >>> QUAD_SHIFT;
      total = signed'({32'h00000000, GAIN_UNITY}) + lin_term + quad_term;
      if (total < 0) begin
         return 16'h0000;
      end else if (total > signed'({32'h00000000, GAIN_MAX})) begin
         return GAIN_MAX;
      end else begin
         return total[15:0];
      end
   endfunction : temp_gain

   // multiply a current sample by eight when enabled
   function automatic logic [31:0] gain8(input logic signed [31:0] i,
                                          input logic en);
      if (en) begin
         return ces_sat32(48'(i) <<< GAIN8_SHIFT);
      end else begin
         return i;
      end
   endfunction : gain8

   // ---- configuration and register port ----

   // processor writes to the configuration word
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         cfg_reg <= CONFIG_RESET;
      end else if (ce_wr_en && ce_addr == ADDR_CONFIG) begin
         cfg_reg <= ce_wdata & CONFIG_WMASK;
      end
   end

   // read data, unmapped words read zero, status is read only
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         ce_rdata <= 32'h00000000;
      end else if (ce_rd_en) begin
         case (ce_addr)
            ADDR_CONFIG: ce_rdata <= cfg_reg;
            ADDR_STATUS: ce_rdata <= status_reg;
            default: ce_rdata <= 32'h00000000;
         endcase
      end
   end

   // ---- phase selection and fundamental ----

   assign phase_sel = {cfg_reg.phase_select_hi, cfg_reg.phase_select_lo};

   // decode phase pair; undefined codes fall back to phase a
   always_comb begin
      case (phase_sel)
         PHASE_A: sel_b = 1'b0;
         PHASE_B: sel_b = 1'b1;
         default: sel_b = 1'b0;
      endcase
   end

   // tracked voltage feeds the fundamental square wave only
   assign sel_voltage = sel_b ? voltage_in_b : voltage_in_a;

   // square wave high on positive half cycles of tracked phase
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         f0_reg <= 1'b0;
      end else if (sample_valid) begin
         f0_reg <= !sel_voltage[31];
      end
   end

   // tracking loop phase choice, updated per sample
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         pll_phase_b <= 1'b0;
      end else if (sample_valid) begin
         pll_phase_b <= sel_b;
      end
   end

   // ---- sag detection ----

   // phase a detector
   ces_sag_detect u_sag_a (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .sample_en(sample_valid),
      .sample(voltage_in_a),
      .sag_threshold(sag_threshold),
      .sag_sample_count(cfg_reg.sag_sample_count),
      .sag(sag_a)
   );

   // phase b detector
   ces_sag_detect u_sag_b (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .sample_en(sample_valid),
      .sample(voltage_in_b),
      .sag_threshold(sag_threshold),
      .sag_sample_count(cfg_reg.sag_sample_count),
      .sag(sag_b)
   );

   // interrupt only while every selected phase is in sag
   assign sag_irq_next = (cfg_reg.sag_mask_lo || cfg_reg.sag_mask_hi)
                         && (!cfg_reg.sag_mask_lo || sag_a)
                         && (!cfg_reg.sag_mask_hi || sag_b);

   // registered sag interrupt and aux pin mux
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         sag_irq <= 1'b0;
         aux_pulse_out <= 1'b0;
      end else begin
         sag_irq <= sag_irq_next;
         if (cfg_reg.sag_int_en) begin
            aux_pulse_out <= sag_irq_next;
         end else begin
            aux_pulse_out <= aux_pulse_src;
         end
      end
   end

   // ---- current gain ----

   // shunt gain per current channel, per sample
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         current_a_scaled <= 32'h00000000;
         current_b_scaled <= 32'h00000000;
      end else if (sample_valid) begin
         current_a_scaled <= gain8(current_in_a,
                                   cfg_reg.current_a_gain8);
         current_b_scaled <= gain8(current_in_b,
                                   cfg_reg.current_b_gain8);
      end
   end

   // ---- pulse generator inputs ----

   // internal pulse inputs chosen by meter equation
   always_comb begin
      int_rates = '0;
      case (meter_equation)
         EQU_SINGLE: begin
            // larger current element feeds the generators
            if (sums.element0_current_sq_sum >
                sums.element1_current_sq_sum) begin
               int_rates.watt = sums.element0_watt_sum;
               int_rates.var_rate = sums.element0_var_sum;
            end else begin
               int_rates.watt = sums.element1_watt_sum;
               int_rates.var_rate = sums.element1_var_sum;
            end
         end
         EQU_DUAL: begin
            // both elements summed
            int_rates.watt = ces_sat32(48'(sums.element0_watt_sum)
                           + 48'(sums.element1_watt_sum));
            int_rates.var_rate = ces_sat32(48'(sums.element0_var_sum)
                               + 48'(sums.element1_var_sum));
         end
         default: begin
            // other equations use element 0
            int_rates.watt = sums.element0_watt_sum;
            int_rates.var_rate = sums.element0_var_sum;
         end
      endcase
   end

   // processor words or internal sums
   assign raw_rates = cfg_reg.pulse_source_external ? ext_rates
                                                    : int_rates;

   // one gain stage per generator
   ces_pulse_scale u_scale_watt (
      .pulse_boost(cfg_reg.pulse_boost),
      .pulse_reduce(cfg_reg.pulse_reduce),
      .value_in(raw_rates.watt),
      .value_out(scaled_rates.watt)
   );

   ces_pulse_scale u_scale_var (
      .pulse_boost(cfg_reg.pulse_boost),
      .pulse_reduce(cfg_reg.pulse_reduce),
      .value_in(raw_rates.var_rate),
      .value_out(scaled_rates.var_rate)
   );

   ces_pulse_scale u_scale_third (
      .pulse_boost(cfg_reg.pulse_boost),
      .pulse_reduce(cfg_reg.pulse_reduce),
      .value_in(raw_rates.third),
      .value_out(scaled_rates.third)
   );

   ces_pulse_scale u_scale_fourth (
      .pulse_boost(cfg_reg.pulse_boost),
      .pulse_reduce(cfg_reg.pulse_reduce),
      .value_in(raw_rates.fourth),
      .value_out(scaled_rates.fourth)
   );

   // ---- pass sequencer ----

   // idle, evaluate, done: one pass per sample frame
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         PASS_IDLE: begin
            if (sample_valid) begin
               state_next = PASS_EVAL;
            end
         end
         PASS_EVAL: state_next = PASS_DONE;
         PASS_DONE: state_next = PASS_IDLE;
         default: state_next = PASS_IDLE;
      endcase
   end

   // state register
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_reg <= PASS_IDLE;
      end else begin
         state_reg <= state_next;
      end
   end

   // gain scale computed during evaluation
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         gain_calc_reg <= GAIN_UNITY;
      end else if (state_reg == PASS_EVAL) begin
         gain_calc_reg <= temp_gain(temp_in);
      end
   end

   // gain scale owner: engine or processor
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         channel_gain_scale <= GAIN_UNITY;
      end else if (cfg_reg.temp_comp_external) begin
         channel_gain_scale <= mpu_gain_scale;
      end else if (state_reg == PASS_DONE) begin
         channel_gain_scale <= gain_calc_reg;
      end
   end

   // pulse rates refreshed at the end of each pass
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         pulse_rates <= '0;
      end else if (state_reg == PASS_EVAL) begin
         pulse_rates <= scaled_rates;
      end
   end

   // status snapshot from live flags, unused bits forced low
   always_comb begin
      status_next = '0;
      status_next.fundamental_square_wave = f0_reg;
      status_next.reserved27 = 1'b0;
      status_next.sag_b = sag_b;
      status_next.sag_a = sag_a;
   end

   // status rewrite and done pulse in the same edge
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         status_reg <= STATUS_RESET;
         pass_done <= 1'b0;
      end else begin
         pass_done <= (state_reg == PASS_EVAL);
         if (state_reg == PASS_EVAL) begin
            status_reg <= status_next;
         end
      end
   end
endmodule : ces_engine

// ==== ces_engine_props.sv ====
// checker: port timing relations of the engine block
module ces_engine_props
   import ces_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic [7:0] ce_addr,
   input wire logic ce_wr_en,
   input wire logic ce_rd_en,
   input wire logic [31:0] ce_rdata,
   input wire logic sample_valid,
   input wire logic aux_pulse_src,
   input wire logic pass_done,
   input wire logic signed [31:0] current_a_scaled,
   input wire ces_pkg::ces_rates_s pulse_rates,
   input wire logic pll_phase_b,
   input wire logic sag_irq,
   input wire logic aux_pulse_out
);
   timeunit 1ns;
   timeprecision 1ps;
   // one clock domain, reset quiets every check
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!rst_n);

   done_pulse_a: assert property (
      pass_done |=> !pass_done) else $error("done pulse too long");
   done_cause_a: assert property (
      pass_done |-> $past(sample_valid, 2)) else $error("done without frame");
   stat_zero_a: assert property (
      $past(ce_rd_en) && $past(ce_addr) == ADDR_STATUS
      |-> ce_rdata[31:29] == 3'h0 && ce_rdata[24:0] == 25'h0)
      else $error("status unused bits set");
   stat_rsvd_a: assert property (
      $past(ce_rd_en) && $past(ce_addr) == ADDR_STATUS |-> !ce_rdata[27])
      else $error("status reserved bit set");
   aux_route_a: assert property (
      aux_pulse_out == sag_irq || aux_pulse_out == $past(aux_pulse_src))
      else $error("aux pin from wrong source");
   irq_cause_a: assert property (
      $changed(sag_irq) |-> $past(sample_valid, 2) || $past(ce_wr_en, 2))
      else $error("sag irq moved without cause");
   cur_cause_a: assert property (
      $changed(current_a_scaled) |-> $past(sample_valid))
      else $error("current moved without frame");
   rate_time_a: assert property (
      $changed(pulse_rates) |-> pass_done) else $error("rates off pass edge");
   pll_cause_a: assert property (
      $changed(pll_phase_b) |-> $past(sample_valid))
      else $error("tracking phase moved without frame");

   // main scenarios reached
   pass_c: cover property (pass_done);
   irq_c: cover property ($rose(sag_irq));
   pll_c: cover property ($rose(pll_phase_b));
endmodule : ces_engine_props

// ==== ces_engine_bench.sv ====
// testbench: register and pass sequences for the engine block
module ces_engine_bench;
   import ces_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic sys_clk, rst_n, ce_wr_en, ce_rd_en, sample_valid, aux_pulse_src;
   logic [7:0] ce_addr;
   logic [31:0] ce_wdata, ce_rdata, sag_threshold;
   logic signed [31:0] voltage_in_a, voltage_in_b, current_in_a;
   logic signed [31:0] current_in_b, current_a_scaled, current_b_scaled;
   logic [2:0] meter_equation;
   logic [15:0] mpu_gain_scale, channel_gain_scale;
   logic pass_done, pll_phase_b, sag_irq, aux_pulse_out;
   ces_sums_s sums;
   ces_rates_s ext_rates, pulse_rates;
   ces_temp_s temp_in;
   ces_cfg_s cfg; // shadow of the configuration word
   logic [3:0][31:0] er, pr; // rate words, watt on top
   int n_fail, compares, i, m;

   ces_engine uut (.sys_clk(sys_clk), .rst_n(rst_n), .ce_addr(ce_addr),
      .ce_wr_en(ce_wr_en), .ce_wdata(ce_wdata), .ce_rd_en(ce_rd_en),
      .ce_rdata(ce_rdata), .sample_valid(sample_valid),
      .voltage_in_a(voltage_in_a), .voltage_in_b(voltage_in_b),
      .current_in_a(current_in_a), .current_in_b(current_in_b),
      .sag_threshold(sag_threshold), .meter_equation(meter_equation),
      .sums(sums), .ext_rates(ext_rates), .temp_in(temp_in),
      .mpu_gain_scale(mpu_gain_scale), .aux_pulse_src(aux_pulse_src),
      .pass_done(pass_done), .current_a_scaled(current_a_scaled),
      .current_b_scaled(current_b_scaled), .pulse_rates(pulse_rates),
      .channel_gain_scale(channel_gain_scale), .pll_phase_b(pll_phase_b),
      .sag_irq(sag_irq), .aux_pulse_out(aux_pulse_out));

   // 25 MHz clock
   initial begin
      sys_clk = 1'b0;
      forever #20 sys_clk = ~sys_clk;
   end

   // verdict and end of run
   task automatic finish_test();
      $display("fails %0d compares %0d", n_fail, compares);
      if (n_fail == 0 && compares > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : finish_test

   // step past the next rising edge
   task automatic tick();
      @(posedge sys_clk);
      #1;
   endtask : tick

   // compare one word, x never matches
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         n_fail++;
         $display("BAD %0t mismatch got %h exp %h", $time, got, exp);
      end
   endtask : chk

   // one word write, strobe for a single edge
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      ce_addr = a;
      ce_wdata = d;
      ce_wr_en = 1'b1;
      tick();
      ce_wr_en = 1'b0;
      tick();
   endtask : wr

   // one word read, data valid the cycle after the strobe
   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      ce_addr = a;
      ce_rd_en = 1'b1;
      tick();
      ce_rd_en = 1'b0;
      chk(ce_rdata, exp);
      tick();
   endtask : rd

   // one sample frame, bounded wait for the pass end
   task automatic frame(input logic signed [31:0] va, vb);
      int n;
      voltage_in_a = va;
      voltage_in_b = vb;
      sample_valid = 1'b1;
      tick();
      sample_valid = 1'b0;
      n = 0;
      while (pass_done !== 1'b1 && n < 4) begin
         tick();
         n++;
      end
      chk(n, 1);
      if (n == 4) begin
         finish_test();
      end
      tick();
   endtask : frame

   // expected status word
   function automatic logic [31:0] st(input logic f, b, a);
      return {3'h0, f, 1'b0, b, a, 25'h0};
   endfunction : st

   // expected pulse input for gain mode m (bit1 boost, bit0 reduce)
   function automatic logic [31:0] sc(input logic signed [31:0] v, int m);
      return m == 1 ? v >>> 6 : m == 2 ? v <<< 4 : v;
   endfunction : sc

   // main sequence
   initial begin
      {ce_wr_en, ce_rd_en, sample_valid, aux_pulse_src} = 4'h0;
      {ce_addr, ce_wdata, voltage_in_a, voltage_in_b} = '0;
      {current_in_a, current_in_b, meter_equation, mpu_gain_scale} = '0;
      {sums, ext_rates, temp_in} = '0;
      sag_threshold = 32'h000003e8;
      n_fail = 0;
      compares = 0;
      rst_n = 1'b0;
      repeat (16) @(posedge sys_clk);
      #1 rst_n = 1'b1;
      tick();
      rd(ADDR_CONFIG, CONFIG_RESET);
      rd(ADDR_STATUS, STATUS_RESET);
      rd(8'h44, 32'h0);
      wr(ADDR_CONFIG, '1);
      rd(ADDR_CONFIG, CONFIG_WMASK);
      wr(ADDR_STATUS, '1);
      rd(ADDR_STATUS, STATUS_RESET);
      // sag on both inputs, count of three
      cfg = CONFIG_RESET;
      cfg.sag_sample_count = 8'h03;
      {cfg.sag_mask_hi, cfg.sag_mask_lo, cfg.sag_int_en} = 3'h7;
      wr(ADDR_CONFIG, cfg);
      for (i = 1; i <= 3; i++) begin
         frame(100, 100);
         rd(ADDR_STATUS, st(1'b1, i == 3, i == 3));
      end
      chk(sag_irq, 1'b1);
      chk(aux_pulse_out, 1'b1);
      frame(5000, 100);
      rd(ADDR_STATUS, st(1'b1, 1'b1, 1'b0));
      chk(sag_irq, 1'b0);
      cfg.sag_mask_lo = 1'b0;
      wr(ADDR_CONFIG, cfg);
      chk(sag_irq, 1'b1);
      cfg.sag_int_en = 1'b0;
      wr(ADDR_CONFIG, cfg);
      tick();
      chk(aux_pulse_out, 1'b0);
      // normal pulse function passes through the pin
      aux_pulse_src = 1'b1;
      tick();
      chk(aux_pulse_out, 1'b1);
      // frequency tracking phase, taken up at the next frame
      cfg.phase_select_lo = 1'b1;
      wr(ADDR_CONFIG, cfg);
      frame(5000, -5000);
      chk(pll_phase_b, 1'b1);
      rd(ADDR_STATUS, st(1'b0, 1'b0, 1'b0));
      cfg.phase_select_lo = 1'b0;
      wr(ADDR_CONFIG, cfg);
      frame(5000, -5000);
      chk(pll_phase_b, 1'b0);
      rd(ADDR_STATUS, st(1'b1, 1'b0, 1'b0));
      // shunt gain on one channel at a time
      {current_in_a, current_in_b} = {32'sd5, -32'sd7};
      for (i = 0; i < 2; i++) begin
         {cfg.current_b_gain8, cfg.current_a_gain8} = i ? 2'h2 : 2'h1;
         wr(ADDR_CONFIG, cfg);
         frame(5000, 5000);
         chk(current_a_scaled, i ? 5 : 40);
         chk(current_b_scaled, i ? -56 : -7);
      end
      // processor rate words through every gain mode
      er = {32'sd6400, -32'sd6400, 32'd640, 32'd64};
      ext_rates = er;
      for (m = 0; m < 4; m++) begin
         {cfg.pulse_boost, cfg.pulse_reduce} = m[1:0];
         wr(ADDR_CONFIG, cfg);
         frame(5000, 5000);
         pr = pulse_rates;
         for (i = 0; i < 4; i++) begin
            chk(pr[i], sc(er[i], m));
         end
      end
      // internal sums, single then dual element
      {cfg.pulse_boost, cfg.pulse_reduce, cfg.pulse_source_external} = 3'h0;
      wr(ADDR_CONFIG, cfg);
      sums.element0_watt_sum = 11;
      sums.element1_watt_sum = 22;
      sums.element0_var_sum = 30;
      sums.element1_var_sum = 40;
      for (i = 0; i < 2; i++) begin
         sums.element0_current_sq_sum = i ? 3 : 5;
         sums.element1_current_sq_sum = i ? 5 : 3;
         frame(5000, 5000);
         chk(pulse_rates.watt, i ? 22 : 11);
         chk(pulse_rates.third, 32'h0);
      end
      meter_equation = EQU_DUAL;
      frame(5000, 5000);
      chk(pulse_rates.watt, 33);
      chk(pulse_rates.var_rate, 70);
      // gain scale owned by the engine, then by the processor
      temp_in.temp_coef_linear = 16'sh4000;
      temp_in.temp_diff = 16'sd4;
      frame(5000, 5000);
      chk(channel_gain_scale, 16'h4004);
      cfg.temp_comp_external = 1'b1;
      mpu_gain_scale = 16'h1234;
      wr(ADDR_CONFIG, cfg);
      chk(channel_gain_scale, 16'h1234);
      frame(5000, 5000);
      chk(channel_gain_scale, 16'h1234);
      finish_test();
   end
endmodule : ces_engine_bench

// attach the port checker to every engine instance
bind ces_engine ces_engine_props u_props (.sys_clk(sys_clk), .rst_n(rst_n),
   .ce_addr(ce_addr), .ce_wr_en(ce_wr_en), .ce_rd_en(ce_rd_en),
   .ce_rdata(ce_rdata), .sample_valid(sample_valid),
   .aux_pulse_src(aux_pulse_src), .pass_done(pass_done),
   .current_a_scaled(current_a_scaled), .pulse_rates(pulse_rates),
   .pll_phase_b(pll_phase_b), .sag_irq(sag_irq),
   .aux_pulse_out(aux_pulse_out));
